/* File: design/pms_pkg.sv */
// Package of constants and types for the priority mask and secure view block.
package pms_pkg;

  // ******************************************************************
  // Register map, byte addresses on the Avalon-MM slave
  // ******************************************************************
  localparam int          PMS_ADDR_W      = 12;
  localparam logic [11:0] PMS_OFS_MASK    = 12'h000;
  localparam logic [11:0] PMS_OFS_RUNNING = 12'h004;
  localparam logic [11:0] PMS_OFS_STATUS  = 12'h008;
  localparam logic [11:0] PMS_OFS_ENABLE  = 12'h00C;
  localparam logic [11:0] PMS_OFS_PRIO    = 12'h100;
  localparam logic [11:0] PMS_OFS_GROUP   = 12'h200;
  localparam int          PMS_NS_ALIAS_BIT = 11;
  localparam int          PMS_MAX_IRQ     = 32;

  // ******************************************************************
  // Field layouts and reset values
  // ******************************************************************
  localparam int          PMS_PRIO_W      = 8;
  localparam int          PMS_PRIO_TOP    = 7;
  localparam logic [7:0]  PMS_MASK_RST    = 8'h00;
  localparam logic [7:0]  PMS_PRIO_RST    = 8'h00;
  localparam logic [7:0]  PMS_IDLE_RUN    = 8'hFF;
  localparam int          PMS_STAT_VALID  = 31;
  localparam int          PMS_STAT_SIG    = 30;
  localparam int          PMS_STAT_ID_LSB = 8;

  typedef enum logic [1:0] {
    PMS_GRP_G0   = 2'h0,
    PMS_GRP_G1S  = 2'h1,
    PMS_GRP_G1NS = 2'h2
  } pms_group_t;

  // Best pending candidate travelling from the selector to the output stage.
  typedef struct packed {
    logic       valid;
    logic [4:0] id;
    logic [7:0] prio;
  } pms_cand_t;

endpackage

/* File: design/pms_core.sv */
// Priority masking, pending selection and secure/non-secure priority views.
`timescale 1ns/1ns

// Summary of operation
// [RULE_01] Signal a pending interrupt only if its priority beats the mask threshold.
// [RULE_02] Mask resets to zero; zero threshold blocks every interrupt.
// [RULE_03] Mask comparison uses the full priority, no group split.
// [RULE_04] Never signal an interrupt at the idle (lowest supported) priority.
// [RULE_05] Writing 0xFF to the mask leaves the lowest supported priority.
// [RULE_06] Non-secure mask access reads zero, ignores writes while stored bit 7 is zero.
// [RULE_07] Priority fields implement 5 to 8 upper bits.
// [RULE_08] Secure accesses reach all implemented bits; unimplemented low bits read zero.
// [RULE_09] Secure reads of a priority field return the stored value untranslated.
// [RULE_10] Non-secure group 1 fields show secure or non-secure view by access security.
// [RULE_11] Non-secure reads show stored value shifted left, bit 0 zero.
// [RULE_12] Non-secure writes store value shifted right with bit 7 set.
// [RULE_13] After a secure write clears bit 7, non-secure read shows low bits shifted.
// [RULE_14] Non-secure writes still change such a field, always setting bit 7.
// [RULE_15] Running priority reads zero to non-secure reads while its bit 7 is zero.
// [RULE_16] Non-secure accesses see nothing of group 0 or secure group 1 priorities.
// [RULE_17] With five bits, secure reads step by 8, non-secure reads by 16.
// [RULE_18] Software should keep group 0 bit 7 clear and secure-written NS bit 7 set.
// [RULE_19] Software may probe range by writing 0xFF and reading back.
// [RULE_20] Rewriting a pending priority never loses nor doubles it; applies promptly.
// [RULE_21] Signalling also requires priority higher than the running priority.
// [RULE_22] Numerically smaller priority means higher priority.
module pms_core
  import pms_pkg::*;
#(
  parameter int NUM_IRQ   = 32,
  parameter int PRIO_BITS = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [PMS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [NUM_IRQ-1:0]    irq_pending,
  input  wire logic [7:0]            active_priority,
  output logic                       irq_signal,
  output logic      [4:0]            irq_id,
  output logic      [7:0]            irq_prio
);

  // ******************************************************************
  // Implemented priority bits
  // ******************************************************************
  // Unimplemented low bits are forced to zero on every store path except the 0xFF reset loads of the running priority and irq_prio.
  localparam logic [7:0] IMPL_MASK = 8'(8'hFF << (PMS_PRIO_W - PRIO_BITS)); // RULE_07
  localparam logic [7:0] IDLE_PRIO = IMPL_MASK;

  logic [7:0]         priority_mask_reg;
  logic [7:0]         running_priority_reg;
  logic [7:0]         prio_field [NUM_IRQ];
  pms_group_t         group_field [NUM_IRQ];
  logic [NUM_IRQ-1:0] irq_enable;
  pms_cand_t          best;
  logic               pass_gate;

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  logic                     req;
  logic                     wr_go;
  logic                     non_secure;
  logic [PMS_ADDR_W-1:0]    ofs;
  logic                     hit_prio;
  logic                     hit_group;
  logic [4:0]               idx;
  logic                     idx_ok;
  logic [NUM_IRQ-1:0]       ns_visible;

  assign req        = avs_read | avs_write;
  assign wr_go      = avs_write & ~avs_waitrequest;
  assign non_secure = avs_address[PMS_NS_ALIAS_BIT];
  assign ofs        = {1'b0, avs_address[PMS_ADDR_W-2:0]};
  assign hit_prio   = (ofs & 12'hF00) == PMS_OFS_PRIO;
  assign hit_group  = (ofs & 12'hF00) == PMS_OFS_GROUP;
  assign idx        = ofs[6:2];
  assign idx_ok     = (ofs[7] == 1'b0) && (32'(idx) < NUM_IRQ);

  // Non-secure code only ever sees non-secure group 1 entries.
  generate
    for (genvar g = 0; g < NUM_IRQ; g++) begin : g_vis
      assign ns_visible[g] = group_field[g] == PMS_GRP_G1NS; // RULE_16
    end
  endgenerate

  // Secure view is raw storage; non-secure view is shifted and bit 0 reads zero.
  function automatic logic [7:0] ns_read_view(input logic [7:0] stored);
    return {stored[6:0], 1'b0} & {IMPL_MASK[6:0], 1'b0}; // RULE_11 RULE_13 RULE_17
  endfunction

  function automatic logic [7:0] ns_write_view(input logic [7:0] wdata);
    return {1'b1, wdata[7:1]} & IMPL_MASK; // RULE_12 RULE_14
  endfunction

  // ******************************************************************
  // Avalon-MM handshake
  // ******************************************************************
  // Every access takes exactly one wait cycle; reads are sampled on the
  // first edge and writes land on the edge that releases the master.
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit_prio && idx_ok) begin
      if (!non_secure) begin
        next_readdata[7:0] = prio_field[idx]; // RULE_09 RULE_10
      end else if (ns_visible[idx]) begin
        next_readdata[7:0] = ns_read_view(prio_field[idx]); // RULE_10
      end
    end else if (hit_group && idx_ok) begin
      if (!non_secure) begin
        next_readdata[1:0] = group_field[idx];
      end
    end else begin
      unique case (ofs)
        PMS_OFS_MASK: begin
          if (!non_secure) begin
            next_readdata[7:0] = priority_mask_reg;
          end else if (priority_mask_reg[PMS_PRIO_TOP]) begin
            next_readdata[7:0] = ns_read_view(priority_mask_reg); // RULE_06
          end
        end
        PMS_OFS_RUNNING: begin
          if (!non_secure) begin
            next_readdata[7:0] = running_priority_reg;
          end else if (running_priority_reg[PMS_PRIO_TOP]) begin
            next_readdata[7:0] = ns_read_view(running_priority_reg); // RULE_15
          end
        end
        PMS_OFS_STATUS: begin
          if (!non_secure || !best.valid || ns_visible[best.id]) begin
            next_readdata[PMS_STAT_VALID]              = best.valid;
            next_readdata[PMS_STAT_SIG]                = irq_signal;
            next_readdata[PMS_STAT_ID_LSB +: 5]        = best.id;
            next_readdata[7:0] = non_secure ? ns_read_view(best.prio) : best.prio;
          end
        end
        PMS_OFS_ENABLE: begin
          next_readdata[NUM_IRQ-1:0] = non_secure ? (irq_enable & ns_visible) : irq_enable;
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // ******************************************************************
  // Priority mask and running priority
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      priority_mask_reg <= PMS_MASK_RST; // RULE_02
    end else if (wr_go && ofs == PMS_OFS_MASK && avs_byteenable[0]) begin
      if (!non_secure) begin
        priority_mask_reg <= avs_writedata[7:0] & IMPL_MASK; // RULE_05 RULE_08
      end else if (priority_mask_reg[PMS_PRIO_TOP]) begin
        priority_mask_reg <= ns_write_view(avs_writedata[7:0]); // RULE_06
      end
    end
  end

  // The running priority tracks the highest active priority of the interface.
  always_ff @(posedge clk) begin
    if (rst) begin
      running_priority_reg <= PMS_IDLE_RUN;
    end else begin
      running_priority_reg <= active_priority & IMPL_MASK;
    end
  end

  // ******************************************************************
  // Per-interrupt priority, group and enable storage
  // ******************************************************************
  generate
    for (genvar n = 0; n < NUM_IRQ; n++) begin : g_irq
      logic sel;
      assign sel = wr_go && idx_ok && (32'(idx) == n);

      always_ff @(posedge clk) begin
        if (rst) begin
          prio_field[n] <= PMS_PRIO_RST;
        end else if (sel && hit_prio && avs_byteenable[0]) begin
          if (!non_secure) begin
            prio_field[n] <= avs_writedata[7:0] & IMPL_MASK; // RULE_08
          end else if (ns_visible[n]) begin
            prio_field[n] <= ns_write_view(avs_writedata[7:0]); // RULE_12 RULE_14
          end
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          group_field[n] <= PMS_GRP_G0;
        end else if (sel && hit_group && !non_secure && avs_byteenable[0]) begin
          group_field[n] <= pms_group_t'(avs_writedata[1:0]);
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          irq_enable[n] <= 1'b0;
        end else if (wr_go && ofs == PMS_OFS_ENABLE && avs_byteenable[n / 8]) begin
          if (!non_secure || ns_visible[n]) begin
            irq_enable[n] <= avs_writedata[n];
          end
        end
      end
    end
  endgenerate

  // ******************************************************************
  // Pending selection and signalling
  // ******************************************************************
  // The best candidate is recomputed every cycle from live storage, so a
  // priority rewrite takes effect on the next edge and the pending state
  // itself is never touched here; nothing is lost or duplicated.
  always_comb begin
    best = '{valid: 1'b0, id: 5'h00, prio: IDLE_PRIO};
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (irq_pending[i] && irq_enable[i]) begin
        if (!best.valid || prio_field[i] < best.prio) begin // RULE_22 RULE_20
          best.valid = 1'b1;
          best.id    = 5'(i);
          best.prio  = prio_field[i];
        end
      end
    end
  end

  // Full priorities are compared; grouping is handled outside this block.
  assign pass_gate = best.valid
                  && (best.prio < priority_mask_reg)     // RULE_01 RULE_02 RULE_03
                  && (best.prio < running_priority_reg)  // RULE_21
                  && (best.prio != IDLE_PRIO);           // RULE_04

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_signal <= 1'b0;
      irq_id     <= 5'h00;
      irq_prio   <= PMS_IDLE_RUN;
    end else begin
      irq_signal <= pass_gate;
      irq_id     <= best.id;
      irq_prio   <= best.prio;
    end
  end

endmodule

/* File: tb/pms_core_asserts.sv */
// Port-level concurrent checks for the priority mask and secure view core.
`timescale 1ns/1ns
module pms_core_asserts
  import pms_pkg::*;
#(
  parameter int NUM_IRQ   = 32,
  parameter int PRIO_BITS = 5
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [PMS_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic [NUM_IRQ-1:0]    irq_pending,
  input wire logic [7:0]            active_priority,
  input wire logic                  irq_signal,
  input wire logic [4:0]            irq_id,
  input wire logic [7:0]            irq_prio
);
  // ******************************************************************
  // Helper state
  // ******************************************************************
  localparam logic [7:0] IMPL = 8'(32'h000000FF << (8 - PRIO_BITS));
  localparam logic [7:0] NS_IMPL = {IMPL[6:0], 1'b0};
  logic               mask_written;
  logic [NUM_IRQ-1:0] pend_q;
  logic [7:0]         act_q;
  logic [7:0]         act_q2;
  wire logic          rd_done = avs_read && !avs_waitrequest;
  // Until software has written the mask, the reset threshold of zero must block everything.
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_written <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address[10:0] == 11'h000) begin
      mask_written <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    pend_q <= irq_pending;
    act_q  <= active_priority;
    act_q2 <= act_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ******************************************************************
  // Assertions
  // ******************************************************************
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  mask_reset_a: assert property (!mask_written |-> !irq_signal)
    else $error("interrupt signalled under reset mask");
  no_idle_a: assert property (irq_signal |-> irq_prio != IMPL && (irq_prio & ~IMPL) == 8'h00)
    else $error("idle or malformed priority signalled");
  pend_gate_a: assert property (irq_signal |-> pend_q[irq_id])
    else $error("signalled interrupt was not pending");
  // The running register lags the core by one edge, so the flag follows it by two.
  run_gate_a: assert property (irq_signal |-> irq_prio < (act_q2 & IMPL))
    else $error("signalled priority not above running priority");
  sec_bits_a: assert property (rd_done && avs_address[11:8] == 4'h1 |->
    avs_readdata[31:8] == 24'h000000 && (avs_readdata[7:0] & ~IMPL) == 8'h00)
    else $error("unimplemented priority bits read nonzero");
  ns_bits_a: assert property (rd_done && avs_address[11:8] == 4'h9 |->
    avs_readdata[31:8] == 24'h000000 && (avs_readdata[7:0] & ~NS_IMPL) == 8'h00)
    else $error("non-secure priority view has stray low bits");
  run_ns_a: assert property (rd_done && avs_address == 12'h804 |-> avs_readdata[0] == 1'b0)
    else $error("non-secure running view bit 0 set");
  cover property (rd_done && avs_address[11]);
  cover property ($rose(irq_signal));
  cover property (irq_signal && act_q != 8'hFF);
endmodule

bind pms_core pms_core_asserts #(.NUM_IRQ(NUM_IRQ), .PRIO_BITS(PRIO_BITS)) u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_pending(irq_pending),
  .active_priority(active_priority), .irq_signal(irq_signal), .irq_id(irq_id),
  .irq_prio(irq_prio));

/* File: tb/pms_cpu_model.sv */
// Behavioural processor core that takes signalled interrupts and reports running priority.
`timescale 1ns/1ns
module pms_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irq_signal,
  input  wire logic [7:0] irq_prio,
  input  wire logic       take,
  input  wire logic       done,
  output logic      [7:0] active_priority
);
  // Only the newest activation is remembered, so nested completion returns straight to idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      active_priority <= 8'hFF;
    end else if (take && irq_signal) begin
      active_priority <= irq_prio;
    end else if (done) begin
      active_priority <= 8'hFF;
    end
  end
endmodule

/* File: tb/pms_core_tb.sv */
// Self-checking bench for the priority mask and secure view core.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pms_core_tb;
  import pms_pkg::*;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, take = 1'b0, done = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, irq_pending = 32'h0;
  logic [7:0]  active_priority, irq_prio;
  logic        avs_waitrequest, irq_signal;
  logic [4:0]  irq_id;
  int          n_errors = 0, samples_checked = 0;
  logic [8:0]  wv [5] = '{9'h05F, 9'h136, 9'h1FF, 9'h000, 9'h100};
  logic [15:0] ev [5] = '{16'h58B0, 16'h9830, 16'hF8F0, 16'h0000, 16'h8000};
  always #5 clk = ~clk;
  pms_core dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_pending(irq_pending),
    .active_priority(active_priority), .irq_signal(irq_signal), .irq_id(irq_id),
    .irq_prio(irq_prio));
  pms_cpu_model cpu (.clk(clk), .rst(rst), .irq_signal(irq_signal), .irq_prio(irq_prio),
    .take(take), .done(done), .active_priority(active_priority));
  // ******************************************************************
  // Bus and check tasks
  // ******************************************************************
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("read %h", a), e, q)
  endtask
  // Three edges cover storage, selection and the registered outputs.
  task automatic sig(input logic s, input logic [4:0] id, input logic [7:0] p);
    repeat (3) @(posedge clk);
    #1;
    `CHK("irq_signal", s, irq_signal)
    if (s) `CHK("irq_id", id, irq_id)
    if (s) `CHK("irq_prio", p, irq_prio)
  endtask
  task automatic pulse(input logic t);
    @(posedge clk);
    if (t) take <= 1'b1; else done <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    done <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rc(12'h000, 32'h0);
    rc(12'h10C, 32'h0);
    rc(12'h040, 32'h0);
    irq_pending <= 32'h8;
    wr(12'h00C, 32'h8);
    sig(1'b0, 5'h0, 8'h0);
    $display("test reset done");
    wr(12'h000, 32'hFF);
    rc(12'h000, 32'hF8);
    rc(12'h800, 32'hF0);
    wr(12'h800, 32'h40);
    rc(12'h000, 32'hA0);
    wr(12'h000, 32'h70);
    rc(12'h800, 32'h0);
    wr(12'h800, 32'hFE);
    rc(12'h000, 32'h70);
    $display("test mask done");
    wr(12'h20C, 32'h2);
    foreach (wv[i]) begin
      wr(wv[i][8] ? 12'h90C : 12'h10C, {24'h0, wv[i][7:0]});
      rc(12'h10C, {24'h0, ev[i][15:8]});
      rc(12'h90C, {24'h0, ev[i][7:0]});
    end
    wr(12'h90C, 32'h36);
    wr(12'h110, 32'h20);
    wr(12'h910, 32'h80);
    rc(12'h910, 32'h0);
    rc(12'h110, 32'h20);
    wr(12'h214, 32'h1);
    wr(12'h114, 32'h40);
    rc(12'h914, 32'h0);
    rc(12'hA0C, 32'h0);
    $display("test views done");
    wr(12'h000, 32'hFF);
    sig(1'b1, 5'd3, 8'h98);
    wr(12'h000, 32'h98);
    sig(1'b0, 5'd3, 8'h98);
    wr(12'h000, 32'hA0);
    sig(1'b1, 5'd3, 8'h98);
    pulse(1'b1);
    sig(1'b0, 5'd3, 8'h98);
    rc(12'h804, 32'h30);
    wr(12'h118, 32'h10);
    wr(12'h00C, 32'h48);
    irq_pending <= 32'h48;
    sig(1'b1, 5'd6, 8'h10);
    rc(12'h008, 32'hC000_0610);
    rc(12'h808, 32'h0);
    rc(12'h80C, 32'h8);
    pulse(1'b1);
    rc(12'h804, 32'h0);
    rc(12'h004, 32'h10);
    pulse(1'b0);
    wr(12'h118, 32'hC8);
    sig(1'b1, 5'd3, 8'h98);
    irq_pending <= 32'h0;
    sig(1'b0, 5'd3, 8'h98);
    wr(12'h00C, 32'h0);
    wr(12'h118, 32'hFF);
    rc(12'h118, 32'hF8);
    $display("test signalling done");
    give_verdict();
  end
endmodule
